// *** hw/lcd_ctrl_pkg.sv ***
// Constants, command codes and register map of the display command controller
package lcd_ctrl_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int FRAME_PERIOD_NS = 16_667_000;
	localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
	localparam int FRAME_COUNT_W = 6;

	// Register byte offsets
	localparam logic [5:0] OFF_CMD = 6'h00;
	localparam logic [5:0] OFF_PARAM = 6'h04;
	localparam logic [5:0] OFF_STATUS = 6'h08;
	localparam logic [5:0] OFF_DISPLAY = 6'h0C;
	localparam logic [5:0] OFF_BLOCK1 = 6'h10;
	localparam logic [5:0] OFF_BLOCK2 = 6'h14;
	localparam logic [5:0] OFF_BLOCK3 = 6'h18;
	localparam logic [5:0] OFF_BLOCK4 = 6'h1C;
	localparam logic [5:0] OFF_MODE = 6'h20;
	localparam logic [5:0] OFF_CURSOR = 6'h24;

	// Command codes
	localparam logic [7:0] CMD_SYS_SETUP = 8'h10;
	localparam logic [7:0] CMD_STANDBY = 8'h11;
	localparam logic [7:0] CMD_PANEL_OFF = 8'h12;
	localparam logic [7:0] CMD_PANEL_ON = 8'h13;
	localparam logic [7:0] CMD_SCROLL = 8'h14;
	localparam logic [7:0] CMD_CSR_SHAPE = 8'h15;
	localparam logic [7:0] CMD_MEM_WRITE = 8'h16;
	localparam logic [7:0] CMD_MEM_READ = 8'h17;
	localparam logic [7:0] CMD_MIX = 8'h18;
	localparam logic [5:0] CMD_STEP_DIR_HI = 6'h07;

	// Parameter byte fields
	localparam int POS_TWO_SCREEN = 3;
	localparam int POS_CURSOR_SHAPE = 7;
	localparam int POS_RENDER1 = 2;
	localparam int POS_RENDER3 = 3;
	localparam int POS_LAYER_COUNT = 4;

	// Cursor step directions
	localparam logic [1:0] DIR_RIGHT = 2'h0;
	localparam logic [1:0] DIR_LEFT = 2'h1;
	localparam logic [1:0] DIR_UP = 2'h2;
	localparam logic [1:0] DIR_DOWN = 2'h3;

	// Layer mix encodings
	localparam logic [1:0] MIX_OR = 2'h0;
	localparam logic [1:0] MIX_XOR = 2'h1;
	localparam logic [1:0] MIX_AND = 2'h2;
	localparam logic [1:0] MIX_PRIO = 2'h3;

	// Flash: frame count compare points for 70 percent on time
	localparam logic [5:0] CURSOR_ON_32 = 6'h16;
	localparam logic [5:0] CURSOR_ON_64 = 6'h2D;

	localparam logic [7:0] RST_FRAME_LINES = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [3:0] PIDX_MAX = 4'hF;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_DRAIN = 2'b01,
		ST_SLEEP = 2'b11
	} power_state_type;
endpackage : lcd_ctrl_pkg

// *** hw/disp_if.sv ***
// Frame timing and layer mixing signals shared among the controller's modules
`timescale 1ns/1ps
interface disp_if;
	logic frame_tick;
	logic [5:0] frame_count;
	logic l1;
	logic l2;
	logic l3;
	logic vis1;
	logic vis2;
	logic vis3;
	logic [1:0] mix;
	logic three_layer;
	logic mixed;
	modport timer (output frame_tick, output frame_count);
	modport mixer (input l1, l2, l3, vis1, vis2, vis3, mix, three_layer, output mixed);
	modport ctrl (input frame_tick, frame_count, mixed,
		output l1, l2, l3, vis1, vis2, vis3, mix, three_layer);
endinterface : disp_if

// *** hw/frame_timer.sv ***
// Frame period divider and frame counter for flash timing
`timescale 1ns/1ps
module frame_timer #(
	parameter int FRAME_CYCLES = lcd_ctrl_pkg::FRAME_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic run,
	disp_if.timer f
);
	localparam int CW = $clog2(FRAME_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(FRAME_CYCLES - 1);
	logic [CW-1:0] cnt_q;
	logic tick_q;
	logic [5:0] frames_q;

	// Counter freezes while the oscillator is halted
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (run) begin
			tick_q <= (cnt_q == LAST);
			cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
		end else begin
			tick_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			frames_q <= '0;
		end else if (tick_q) begin
			frames_q <= frames_q + 6'h01;
		end
	end

	assign f.frame_tick = tick_q;
	assign f.frame_count = frames_q;
endmodule : frame_timer

// *** hw/layer_mixer.sv ***
// Per-pixel composition of the three display layers
`timescale 1ns/1ps
module layer_mixer (
	disp_if.mixer m
);
	logic a;
	logic b;
	logic c;

	// Layers are combined whole, never per screen block
	always_comb begin
		a = m.l1 & m.vis1;
		b = m.l2 & m.vis2;
		c = m.l3 & m.vis3 & m.three_layer;
		unique case (m.mix)
			lcd_ctrl_pkg::MIX_OR: m.mixed = a | b | c;
			lcd_ctrl_pkg::MIX_XOR: m.mixed = (a ^ b) | c;
			lcd_ctrl_pkg::MIX_AND: m.mixed = (a & b) | c;
			// A set pixel of a higher layer hides lower ones even when flashed off
			lcd_ctrl_pkg::MIX_PRIO: m.mixed = m.l1 ? a : (m.l2 ? b : c);
		endcase
	end
endmodule : layer_mixer

// *** hw/lcd_cmd_ctrl.sv ***
// Command interpreter, configuration registers, sleep control and pixel gating
`timescale 1ns/1ps
module lcd_cmd_ctrl #(
	parameter int FRAME_CYCLES = lcd_ctrl_pkg::FRAME_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic pix_valid,
	input wire logic pix_l1,
	input wire logic pix_l2,
	input wire logic pix_l3,
	input wire logic [7:0] pix_line,
	input wire logic pix_lower,
	input wire logic pix_at_cursor,
	input wire logic pix_cursor_row_last,
	output logic pixel_out,
	output logic pixel_valid_out,
	output logic row_driver_disable_n,
	output logic column_blank,
	output logic mem_ctrl_hold,
	output logic host_bus_release,
	output logic osc_run
);
	disp_if d ();

	lcd_ctrl_pkg::power_state_type state_q;
	logic wait_q, drain_seen_q, row_dis_n_q, blank_q, hold_q, osc_q, pix_q, pix_v_q;
	logic [31:0] rdata_q;
	logic [7:0] cmd_q;
	logic [3:0] pidx_q;

	logic panel_enable_q, cursor_shape_q, render1_q, render3_q, layer_count_q, two_screen_q;
	logic cursor_force_q;
	logic [1:0] cursor_flash_q, step_dir_q, mix_q;
	logic [5:0] attr_q;
	logic [15:0] first_start_q, second_start_q, fourth_start_q, pitch_q, cursor_q;
	logic [7:0] first_lines_q, second_lines_q, frame_lines_q;

	logic req, wr_acc, rd_acc, cmd_wr, par_wr, sleeping, wake, mem_rd_step;
	logic line_blank, cursor_vis, cursor_hit;
	logic [5:0] reg_off;
	logic [7:0] p;
	logic [15:0] third_start;
	logic [8:0] half_lines;
	logic [31:0] rd_mux;

	// Block attribute visibility for the current frame count
	function automatic logic attr_on(input logic [1:0] fld, input logic [5:0] cnt);
		logic r;
		r = 1'b0;
		unique case (fld)
			2'b00: r = 1'b0;
			2'b01: r = 1'b1;
			2'b10: r = ~cnt[4];
			2'b11: r = ~cnt[1];
		endcase
		return r;
	endfunction : attr_on

	// Next cursor address after one memory access
	function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] dir,
		input logic [15:0] pitch);
		logic [15:0] r;
		r = a;
		unique case (dir)
			lcd_ctrl_pkg::DIR_RIGHT: r = a + 16'h0001;
			lcd_ctrl_pkg::DIR_LEFT: r = a - 16'h0001;
			lcd_ctrl_pkg::DIR_UP: r = a - pitch;
			lcd_ctrl_pkg::DIR_DOWN: r = a + pitch;
		endcase
		return r;
	endfunction : step

	frame_timer #(
		.FRAME_CYCLES(FRAME_CYCLES)
	) u_timer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(osc_q),
		.f(d.timer)
	);

	layer_mixer u_mixer (
		.m(d.mixer)
	);

	// Bus decode; a request completes on the edge where waitrequest is seen low
	assign req = avs_read | avs_write;
	assign wr_acc = avs_write & ~wait_q;
	assign rd_acc = avs_read & ~wait_q;
	assign reg_off = {avs_address[5:2], 2'b00};
	assign p = avs_writedata[7:0];
	assign sleeping = (state_q == lcd_ctrl_pkg::ST_SLEEP);
	// While asleep only the system setup command and its first byte get through
	assign cmd_wr = wr_acc && reg_off == lcd_ctrl_pkg::OFF_CMD &&
		(!sleeping || p == lcd_ctrl_pkg::CMD_SYS_SETUP);
	assign par_wr = wr_acc && reg_off == lcd_ctrl_pkg::OFF_PARAM &&
		(!sleeping || (cmd_q == lcd_ctrl_pkg::CMD_SYS_SETUP && pidx_q == 4'h0));
	assign wake = sleeping && par_wr;
	assign mem_rd_step = rd_acc && reg_off == lcd_ctrl_pkg::OFF_PARAM &&
		cmd_q == lcd_ctrl_pkg::CMD_MEM_READ && !sleeping;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
		end else if (req && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read && wait_q) begin
			rdata_q <= rd_mux;
		end
	end

	// Command byte starts a new parameter sequence
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmd_q <= 8'h00;
			pidx_q <= 4'h0;
		end else if (cmd_wr) begin
			cmd_q <= p;
			pidx_q <= 4'h0;
		end else if (par_wr && pidx_q != lcd_ctrl_pkg::PIDX_MAX) begin
			pidx_q <= pidx_q + 4'h1;
		end
	end

	// Sleep entry: blank at once, rows off on the second frame tick
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= lcd_ctrl_pkg::ST_RUN;
			drain_seen_q <= 1'b0;
		end else begin
			unique case (state_q)
				lcd_ctrl_pkg::ST_RUN: begin
					drain_seen_q <= 1'b0;
					if (cmd_wr && p == lcd_ctrl_pkg::CMD_STANDBY) begin
						state_q <= lcd_ctrl_pkg::ST_DRAIN;
					end
				end
				lcd_ctrl_pkg::ST_DRAIN: begin
					if (d.frame_tick) begin
						drain_seen_q <= 1'b1;
						if (drain_seen_q) begin
							state_q <= lcd_ctrl_pkg::ST_SLEEP;
						end
					end
				end
				lcd_ctrl_pkg::ST_SLEEP: begin
					if (wake) begin
						state_q <= lcd_ctrl_pkg::ST_RUN;
					end
				end
				default: state_q <= lcd_ctrl_pkg::ST_RUN;
			endcase
		end
	end

	// Pin levels follow the power state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			row_dis_n_q <= 1'b1;
			blank_q <= 1'b0;
			hold_q <= 1'b0;
			osc_q <= 1'b1;
		end else begin
			row_dis_n_q <= !((state_q == lcd_ctrl_pkg::ST_DRAIN && d.frame_tick && drain_seen_q)
				|| (sleeping && !wake));
			blank_q <= (state_q == lcd_ctrl_pkg::ST_DRAIN) || (sleeping && !wake) ||
				(state_q == lcd_ctrl_pkg::ST_RUN && cmd_wr && p == lcd_ctrl_pkg::CMD_STANDBY);
			hold_q <= (state_q == lcd_ctrl_pkg::ST_DRAIN && d.frame_tick && drain_seen_q) ||
				(sleeping && !wake);
			osc_q <= !((state_q == lcd_ctrl_pkg::ST_DRAIN && d.frame_tick && drain_seen_q) ||
				(sleeping && !wake));
		end
	end

	// Configuration: only bytes actually received update a field
	// Sleep neither clears nor reloads these
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			panel_enable_q <= 1'b0;
			cursor_flash_q <= 2'b00;
			attr_q <= 6'h00;
			first_start_q <= lcd_ctrl_pkg::RST_WORD;
			first_lines_q <= 8'h00;
			second_start_q <= lcd_ctrl_pkg::RST_WORD;
			second_lines_q <= 8'h00;
			fourth_start_q <= lcd_ctrl_pkg::RST_WORD;
			cursor_shape_q <= 1'b0;
			mix_q <= lcd_ctrl_pkg::MIX_OR;
			render1_q <= 1'b0;
			render3_q <= 1'b0;
			layer_count_q <= 1'b0;
			two_screen_q <= 1'b0;
			frame_lines_q <= lcd_ctrl_pkg::RST_FRAME_LINES;
			pitch_q <= lcd_ctrl_pkg::RST_WORD;
		end else if (par_wr) begin
			unique case (cmd_q)
				lcd_ctrl_pkg::CMD_SYS_SETUP: begin
					unique case (pidx_q)
						4'h0: two_screen_q <= p[lcd_ctrl_pkg::POS_TWO_SCREEN];
						4'h1: frame_lines_q <= p;
						4'h2: pitch_q[7:0] <= p;
						4'h3: pitch_q[15:8] <= p;
						default: ;
					endcase
				end
				lcd_ctrl_pkg::CMD_PANEL_OFF, lcd_ctrl_pkg::CMD_PANEL_ON: begin
					if (pidx_q == 4'h0) begin
						panel_enable_q <= cmd_q[0];
						cursor_flash_q <= p[1:0];
						attr_q <= p[7:2];
					end
				end
				lcd_ctrl_pkg::CMD_SCROLL: begin
					unique case (pidx_q)
						4'h0: first_start_q[7:0] <= p;
						4'h1: first_start_q[15:8] <= p;
						4'h2: first_lines_q <= p;
						4'h3: second_start_q[7:0] <= p;
						4'h4: second_start_q[15:8] <= p;
						4'h5: second_lines_q <= p;
						// Third start is derived, so its two bytes are consumed unused
						4'h8: fourth_start_q[7:0] <= p;
						4'h9: fourth_start_q[15:8] <= p;
						default: ;
					endcase
				end
				lcd_ctrl_pkg::CMD_CSR_SHAPE: begin
					if (pidx_q == 4'h0) begin
						cursor_shape_q <= p[lcd_ctrl_pkg::POS_CURSOR_SHAPE];
					end
				end
				lcd_ctrl_pkg::CMD_MIX: begin
					if (pidx_q == 4'h0) begin
						mix_q <= p[1:0];
						render1_q <= p[lcd_ctrl_pkg::POS_RENDER1];
						render3_q <= p[lcd_ctrl_pkg::POS_RENDER3];
						layer_count_q <= p[lcd_ctrl_pkg::POS_LAYER_COUNT];
					end
				end
				default: ;
			endcase
		end
	end

	// Step direction is carried in the low bits of the command code
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			step_dir_q <= lcd_ctrl_pkg::DIR_RIGHT;
		end else if (cmd_wr && p[7:2] == lcd_ctrl_pkg::CMD_STEP_DIR_HI) begin
			step_dir_q <= p[1:0];
		end
	end

	// Cursor address: direct write, or one step per memory data byte
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cursor_q <= lcd_ctrl_pkg::RST_WORD;
		end else if (wr_acc && reg_off == lcd_ctrl_pkg::OFF_CURSOR && !sleeping) begin
			cursor_q <= avs_writedata[15:0];
		end else if ((par_wr && cmd_q == lcd_ctrl_pkg::CMD_MEM_WRITE) || mem_rd_step) begin
			cursor_q <= step(cursor_q, step_dir_q, pitch_q);
		end
	end

	// Held until another command arrives, so back-to-back writes keep it lit
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cursor_force_q <= 1'b0;
		end else if (cmd_wr) begin
			cursor_force_q <= (p == lcd_ctrl_pkg::CMD_MEM_WRITE);
		end
	end

	// Third block shares the start of the shorter of the first two
	assign third_start = (first_lines_q <= second_lines_q) ? first_start_q : second_start_q;
	assign half_lines = ({1'b0, frame_lines_q} + 9'h001) >> 1;
	// Lines beyond a block's count up to half frame are blank in two-screen mode
	assign line_blank = two_screen_q && ({1'b0, pix_line} < half_lines) &&
		(pix_line > (pix_lower ? second_lines_q : first_lines_q));

	always_comb begin
		cursor_vis = 1'b0;
		unique case (cursor_flash_q)
			2'b00: cursor_vis = 1'b0;
			2'b01: cursor_vis = 1'b1;
			2'b10: cursor_vis = d.frame_count[4:0] < lcd_ctrl_pkg::CURSOR_ON_32[4:0];
			2'b11: cursor_vis = d.frame_count < lcd_ctrl_pkg::CURSOR_ON_64;
		endcase
		if (cursor_force_q) begin
			cursor_vis = 1'b1;
		end
	end

	// Underscore cursor lights only the last row of the character cell
	assign cursor_hit = pix_at_cursor && cursor_vis &&
		(cursor_shape_q || pix_cursor_row_last);

	assign d.l1 = pix_l1;
	assign d.l2 = pix_l2;
	assign d.l3 = pix_l3;
	assign d.vis1 = attr_on(attr_q[1:0], d.frame_count);
	// The second pair also drives the fourth block, no separate control
	assign d.vis2 = attr_on(attr_q[3:2], d.frame_count);
	assign d.vis3 = attr_on(attr_q[5:4], d.frame_count);
	assign d.mix = mix_q;
	// A text first layer leaves no room for the third layer
	assign d.three_layer = layer_count_q & render1_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pix_q <= 1'b0;
			pix_v_q <= 1'b0;
		end else begin
			pix_v_q <= pix_valid;
			// Panel off wins over every block attribute blanking covers sleep
			pix_q <= pix_valid && panel_enable_q && !line_blank &&
				state_q == lcd_ctrl_pkg::ST_RUN && (d.mixed || cursor_hit);
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (reg_off)
			lcd_ctrl_pkg::OFF_CMD: rd_mux = {24'h00_0000, cmd_q};
			lcd_ctrl_pkg::OFF_PARAM: rd_mux = {28'h000_0000, pidx_q};
			lcd_ctrl_pkg::OFF_STATUS: rd_mux = {26'h000_0000, cursor_force_q, osc_q,
				hold_q, row_dis_n_q, state_q};
			lcd_ctrl_pkg::OFF_DISPLAY: rd_mux = {23'h00_0000, panel_enable_q, attr_q,
				cursor_flash_q};
			lcd_ctrl_pkg::OFF_BLOCK1: rd_mux = {8'h00, first_lines_q, first_start_q};
			lcd_ctrl_pkg::OFF_BLOCK2: rd_mux = {8'h00, second_lines_q, second_start_q};
			lcd_ctrl_pkg::OFF_BLOCK3: rd_mux = {16'h0000, third_start};
			lcd_ctrl_pkg::OFF_BLOCK4: rd_mux = {16'h0000, fourth_start_q};
			lcd_ctrl_pkg::OFF_MODE: rd_mux = {frame_lines_q, pitch_q, two_screen_q,
				layer_count_q, render3_q, render1_q, mix_q, step_dir_q};
			lcd_ctrl_pkg::OFF_CURSOR: rd_mux = {15'h0000, cursor_shape_q, cursor_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign pixel_out = pix_q;
	assign pixel_valid_out = pix_v_q;
	assign row_driver_disable_n = row_dis_n_q;
	assign column_blank = blank_q;
	assign mem_ctrl_hold = hold_q;
	assign host_bus_release = hold_q;
	assign osc_run = osc_q;
endmodule : lcd_cmd_ctrl

// *** verif/lcd_cmd_checker.sv ***
// Port-level assertions for the display command controller
`timescale 1ns/1ps
module lcd_cmd_checker #(
	parameter int FRAME_CYCLES = 16
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic pix_valid,
	input wire logic pixel_out,
	input wire logic pixel_valid_out,
	input wire logic row_driver_disable_n,
	input wire logic column_blank,
	input wire logic mem_ctrl_hold,
	input wire logic host_bus_release,
	input wire logic osc_run
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Bounds assume a 16 cycle frame; bias must survive one whole blank frame
	sequence s_drain;
		row_driver_disable_n [*8] ##1 row_driver_disable_n [*8];
	endsequence
	sequence s_off;
		!row_driver_disable_n;
	endsequence
	property p_sleep_delay;
		$rose(column_blank) |-> s_drain ##[1:18] s_off;
	endproperty
	a_sleep_delay: assert property (p_sleep_delay) else $error("row disable timing wrong");
	property p_wait_ans;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	property p_sleep_blank;
		!row_driver_disable_n |-> column_blank;
	endproperty
	a_sleep_blank: assert property (p_sleep_blank) else $error("columns not blank");
	property p_sleep_hold;
		mem_ctrl_hold |-> host_bus_release && !osc_run && !row_driver_disable_n;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep outputs split");
	property p_pix_blank;
		column_blank ##1 column_blank |-> !pixel_out;
	endproperty
	a_pix_blank: assert property (p_pix_blank) else $error("pixel while blank");
	property p_valid_pipe;
		1'b1 |=> pixel_valid_out == $past(pix_valid);
	endproperty
	a_valid_pipe: assert property (p_valid_pipe) else $error("pixel valid delay wrong");
	property p_wake_write;
		$fell(mem_ctrl_hold) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3);
	endproperty
	a_wake_write: assert property (p_wake_write) else $error("woke without write");
endmodule : lcd_cmd_checker

bind lcd_cmd_ctrl lcd_cmd_checker #(.FRAME_CYCLES(FRAME_CYCLES)) u_checker (
	.ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .pix_valid(pix_valid), .pixel_out(pixel_out),
	.pixel_valid_out(pixel_valid_out), .row_driver_disable_n(row_driver_disable_n),
	.column_blank(column_blank), .mem_ctrl_hold(mem_ctrl_hold),
	.host_bus_release(host_bus_release), .osc_run(osc_run)
);

// *** verif/host_model.sv ***
// Host processor model issuing single register transfers on request
`timescale 1ns/1ps
module host_model (
	input wire logic ref_clk,
	input wire logic go,
	input wire logic we,
	input wire logic [5:0] adr,
	input wire logic [31:0] dat,
	output logic [5:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	output logic done,
	output logic [31:0] rdata
);
	initial begin
		{avs_read, avs_write, done, avs_address} = 9'h000;
		avs_writedata = 32'h0000_0000;
	end
	always @(posedge ref_clk) begin
		done <= 1'b0;
		if (!avs_read && !avs_write) begin
			if (go) begin
				avs_address <= adr;
				avs_read <= !we;
				avs_write <= we;
				avs_writedata <= dat;
			end
		end else if (!avs_waitrequest) begin
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			// Released data flips so stale bytes never look valid
			avs_writedata <= ~avs_writedata;
			rdata <= avs_readdata;
			done <= 1'b1;
		end
	end
endmodule : host_model

// *** verif/testbench.sv ***
// Self-checking bench for the display command controller
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic go = 1'b0;
	logic we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [15:0] pc = 16'h0000;
	logic [15:0] pq;
	logic pix_o;
	logic [5:0] av_a;
	logic av_r, av_w, av_wait, done;
	logic [31:0] av_wd, av_rd, rdata;
	logic [7:0] sp [6] = '{8'h34, 8'h12, 8'h20, 8'h00, 8'h50, 8'h10};
	logic [7:0] dc [3] = '{8'h1F, 8'h1E, 8'h1D};
	logic [15:0] da [3] = '{16'h0112, 16'h0102, 16'h0101};
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) pc <= rst_n ? pc + 16'h0001 : 16'h0000;
	host_model u_host (.ref_clk(ref_clk), .go(go), .we(we), .adr(adr), .dat(dat),
		.avs_address(av_a), .avs_read(av_r), .avs_write(av_w), .avs_writedata(av_wd),
		.avs_readdata(av_rd), .avs_waitrequest(av_wait), .done(done), .rdata(rdata));
	lcd_cmd_ctrl #(.FRAME_CYCLES(16)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(av_a), .avs_read(av_r), .avs_write(av_w), .avs_writedata(av_wd),
		.avs_readdata(av_rd), .avs_waitrequest(av_wait), .pix_valid(pc[0]), .pix_l1(pc[1]),
		.pix_l2(pc[2]), .pix_l3(pc[3]), .pix_line(pc[11:4]), .pix_lower(pc[12]),
		.pix_at_cursor(pc[13]), .pix_cursor_row_last(pc[14]), .pixel_out(pix_o),
		.pixel_valid_out(), .row_driver_disable_n(), .column_blank(), .mem_ctrl_hold(),
		.host_bus_release(), .osc_run());
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	task automatic fail(input string s);
		error_cnt++;
		$display("MISMATCH %0t %s", $time, s);
	endtask : fail
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge ref_clk);
		go <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge ref_clk);
		go <= 1'b0;
		while (done !== 1'b1 && k < 40) begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 40) fail("bus hang");
	endtask : bus
	task automatic chk(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		samples_checked++;
		if (rdata !== e) fail($sformatf("addr %h got %h exp %h", a, rdata, e));
	endtask : chk
	task automatic cmd(input logic [7:0] c);
		bus(1'b1, 6'h00, {24'h00_0000, c});
	endtask : cmd
	task automatic prm(input logic [7:0] p);
		bus(1'b1, 6'h04, {24'h00_0000, p});
	endtask : prm
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail("timeout");
			print_verdict;
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		chk(6'h08, 32'h0000_0014);
		chk(6'h20, 32'h0000_0000);
		bus(1'b1, 6'h3C, 32'h0000_00FF);
		chk(6'h3C, 32'h0000_0000);
		$display("test reset done");
		cmd(8'h13);
		prm(8'hB6);
		chk(6'h0C, 32'h0000_01B6);
		cmd(8'h12);
		prm(8'h01);
		chk(6'h0C, 32'h0000_0001);
		$display("test panel done");
		cmd(8'h14);
		foreach (sp[i]) prm(sp[i]);
		chk(6'h10, 32'h0020_1234);
		chk(6'h14, 32'h0010_5000);
		chk(6'h18, 32'h0000_5000);
		cmd(8'h14);
		prm(8'h78);
		chk(6'h10, 32'h0020_1278);
		chk(6'h14, 32'h0010_5000);
		$display("test scroll done");
		cmd(8'h10);
		prm(8'h00);
		prm(8'h07);
		prm(8'h10);
		prm(8'h00);
		cmd(8'h15);
		prm(8'h80);
		bus(1'b1, 6'h24, 32'h0000_0100);
		cmd(8'h1C);
		cmd(8'h16);
		prm(8'hAA);
		prm(8'hBB);
		chk(6'h24, 32'h0001_0102);
		chk(6'h08, 32'h0000_0034);
		for (int i = 0; i < 3; i++) begin
			cmd(dc[i]);
			cmd(8'h16);
			prm(8'hCC);
			chk(6'h24, {16'h0001, da[i]});
		end
		cmd(8'h17);
		chk(6'h04, 32'h0000_0000);
		chk(6'h24, 32'h0001_0100);
		$display("test cursor done");
		for (int m = 0; m < 4; m++) begin
			cmd(8'h18);
			prm(8'h0C | 8'(m));
			chk(6'h20, 32'h0700_1031 | (32'(m) << 2));
		end
		for (int d = 0; d < 4; d++) begin
			cmd(8'h1C + 8'(d));
			chk(6'h20, 32'h0700_103C | 32'(d));
		end
		cmd(8'h18);
		prm(8'h1F);
		chk(6'h20, 32'h0700_107F);
		$display("test mode done");
		cmd(8'h11);
		n = 0;
		while (u_dut.row_driver_disable_n !== 1'b0 && n < 80) begin
			@(posedge ref_clk);
			n++;
		end
		samples_checked++;
		if (n >= 80) fail("no sleep");
		chk(6'h08, 32'h0000_000B);
		cmd(8'h13);
		prm(8'h00);
		cmd(8'h10);
		prm(8'h00);
		chk(6'h08, 32'h0000_0014);
		chk(6'h0C, 32'h0000_0001);
		chk(6'h10, 32'h0020_1278);
		chk(6'h20, 32'h0700_107F);
		cmd(8'h13);
		prm(8'h05);
		chk(6'h0C, 32'h0000_0105);
		// Pixel launched at the last edge came from the counter value one step back
		for (int j = 0; j < 32; j++) begin
			@(negedge ref_clk);
			pq = pc - 16'h0001;
			samples_checked++;
			if (pix_o !== (pq[0] && (pq[1] || pq[13]))) fail("pixel");
		end
		$display("test sleep done");
		print_verdict;
	end
endmodule : testbench
